// >>> logic/host_port_pkg.sv
// shared constants, modes and register map of the parallel host register port
package host_port_pkg;
   localparam int IDX_W       = 11;
   localparam int DATA_W      = 8;
   localparam int REG_W       = 8;
   localparam int SYS_CLK_NS  = 50;
   // ready/acknowledge deadline after the strobe, in ns, and in sys_clk cycles (rounded down)
   localparam int ACK_MAX_NS  = 150;
   localparam int ACK_MAX_CYC = (ACK_MAX_NS / SYS_CLK_NS) < 1 ? 1 : (ACK_MAX_NS / SYS_CLK_NS);
   // host waits from select to strobe, in ns, and in cycles (rounded up)
   localparam int CS_TO_STB_NS  = 30;
   localparam int CS_TO_STB_CYC = (CS_TO_STB_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   // least host bus clock period in ns
   localparam int BUS_CLK_MIN_NS = 20;
   // register map
   localparam logic [7:0] CHAN_LAST      = 8'hdf;
   localparam int         CHAN_COUNT     = 14;
   localparam int         CHAN_REGS      = 16;
   localparam logic [7:0] GLOBAL_FIRST   = 8'he0;
   localparam logic [7:0] GLOBAL_LAST    = 8'heb;
   localparam logic [7:0] TEST_FIRST     = 8'hec;
   localparam logic [7:0] TEST_LAST      = 8'hfd;
   localparam logic [7:0] E1_ARB_SEL_OFF = 8'hf4;
   localparam logic [7:0] DEV_ID_OFF     = 8'hfe;
   localparam logic [7:0] DEV_REV_OFF    = 8'hff;
   localparam logic [7:0] REG_RESET      = 8'h00;
   typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_DSTROBE} port_mode_e;
endpackage : host_port_pkg

// >>> logic/host_port_if.sv
// pin bundle between the host and the register port device
`timescale 1ns/100ps
interface host_port_if;
   logic [10:0] index;
   logic        cs_n;
   logic        latch_or_start_pin;
   logic        rd_stb_n;
   logic        wr_rw;
   logic        bus_clk;
   logic        ready_or_ack_pin;
   logic [7:0]  data_host;
   logic        data_host_oe;
   logic [7:0]  data_dev;
   logic        data_dev_oe;
   modport device (input index, cs_n, latch_or_start_pin, rd_stb_n, wr_rw, bus_clk, data_host, data_host_oe,
                   output ready_or_ack_pin, data_dev, data_dev_oe);
   modport host (output index, cs_n, latch_or_start_pin, rd_stb_n, wr_rw, bus_clk, data_host, data_host_oe,
                 input ready_or_ack_pin, data_dev, data_dev_oe);
endinterface : host_port_if

// >>> logic/host_register_port.sv
// device end: strobe decode, index latch, register file and ready handshake
`timescale 1ns/100ps
module host_register_port
   import host_port_pkg::*;
#(
   parameter logic [2:0] CHIP_SEL  = 3'h0,
   parameter logic [7:0] DEV_ID    = 8'h5a, // arbitrary value
   parameter logic [7:0] DEV_REV   = 8'h01, // arbitrary value
   parameter int         ACK_DELAY = 1
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // mode strap
   input  wire host_port_pkg::port_mode_e mode,
   // pins
   host_port_if.device                  pins,
   // global settings seen by the channels, and the port busy flag
   output logic [7:0]                   global_ctrl0,
   output logic [7:0]                   e1_arbitrary_pulse_select,
   output logic                         busy
);
   import host_port_pkg::*;

   // two sync stages plus ACK_DELAY edges must still fit the ready deadline
   if (ACK_DELAY < 1 || ACK_DELAY > ACK_MAX_CYC - 2 || ACK_DELAY > 5) begin : g_bad_ack_delay
      $error("ACK_DELAY out of range");
   end

   typedef enum logic [1:0] {IDLE, WAIT_ACK, ACKED} cyc_e;

   // two-stage synchronisers on every input pin except data_host_oe
   logic [10:0] idx_s1, idx_s2;
   logic        cs_s1, cs_s2;
   logic        lat_s1, lat_s2;
   logic        rd_s1, rd_s2;
   logic        rw_s1, rw_s2;
   logic        clk_s1, clk_s2;
   logic [7:0]  dat_s1, dat_s2;
   logic        lat_prev_q;
   logic        stb_prev_q;
   logic [7:0]  idx_q;
   logic        idx_held_q;
   logic [7:0]  regs_q [0:255];
   cyc_e        state_q;
   logic [1:0]  wait_q;
   logic        is_read_q;
   logic        ack_q;
   logic        drive_q;
   logic [7:0]  rdata_q;

   always_ff @(posedge sys_clk) begin
      // multi-bit index and data are settled long before the strobe that uses them
      idx_s1 <= pins.index;
      idx_s2 <= idx_s1;
      cs_s1  <= pins.cs_n;
      cs_s2  <= cs_s1;
      lat_s1 <= pins.latch_or_start_pin;
      lat_s2 <= lat_s1;
      rd_s1  <= pins.rd_stb_n;
      rd_s2  <= rd_s1;
      rw_s1  <= pins.wr_rw;
      rw_s2  <= rw_s1;
      clk_s1 <= pins.bus_clk;
      clk_s2 <= clk_s1;
      dat_s1 <= pins.data_host;
      dat_s2 <= dat_s1;
   end

   // select and index pass the same two stages as the strobes, so they line up
   wire sel       = !cs_s2 && idx_s2[10:8] == CHIP_SEL;
   wire lat_fall  = lat_prev_q && !lat_s2;
   wire start_low = !lat_s2;
   // strobe per mode: async uses separate read/store pins, others share rd pin with direction
   wire rd_stb    = !rd_s2;
   wire wr_stb    = (mode == MODE_ASYNC) ? !rw_s2 : 1'b0;
   wire stb       = (mode == MODE_ASYNC) ? (rd_stb || wr_stb) : rd_stb;
   // a strobe held low over many cycles opens only one cycle
   wire stb_rise  = stb && !stb_prev_q;
   wire cyc_read  = (mode == MODE_ASYNC) ? rd_stb : rw_s2;
   // latch tied high never falls: index bus used as presented
   wire [7:0] eff_idx = idx_held_q ? idx_q : idx_s2[7:0];
   wire is_chan   = eff_idx <= CHAN_LAST;
   wire is_glob   = eff_idx >= GLOBAL_FIRST && eff_idx <= GLOBAL_LAST;
   wire is_test   = eff_idx >= TEST_FIRST && eff_idx <= TEST_LAST;
   wire writable  = is_chan || is_glob || is_test;
   wire       hit_id  = eff_idx == DEV_ID_OFF;
   wire       hit_rev = eff_idx == DEV_REV_OFF;
   wire [7:0] rd_val  = hit_id ? DEV_ID : hit_rev ? DEV_REV : regs_q[eff_idx];
   wire [3:0] chan_no = eff_idx[7:4];
   wire       chan_ok = chan_no < 4'(CHAN_COUNT) && 4'(CHAN_REGS - 1) == 4'hf;
   // a fresh strobe edge opens the cycle; with ACK_DELAY 1 ready goes out on that same edge
   wire start_cyc = state_q == IDLE && sel && stb_rise;
   wire fast_ack  = ACK_DELAY == 1;
   wire ack_edge  = (start_cyc && fast_ack) || (state_q == WAIT_ACK && stb && wait_q == 2'h0);
   wire ack_read  = (state_q == IDLE) ? cyc_read : is_read_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // low, so no false latch fall right after reset
         lat_prev_q <= 1'b0;
         stb_prev_q <= 1'b0;
         idx_q      <= 8'h00;
         idx_held_q <= 1'b0;
      end else begin
         lat_prev_q <= lat_s2;
         stb_prev_q <= stb;
         // index held from the latch until select drops; a tied-high latch never falls
         if (cs_s2) begin
            idx_held_q <= 1'b0;
         end else if (mode == MODE_SYNC ? (start_low && !idx_held_q) : lat_fall) begin
            idx_q      <= idx_s2[7:0];
            idx_held_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q   <= IDLE;
         wait_q    <= 2'h0;
         is_read_q <= 1'b0;
         ack_q     <= 1'b0;
         drive_q   <= 1'b0;
         rdata_q   <= 8'h00;
      end else begin
         unique case (state_q)
            IDLE: begin
               if (start_cyc) begin
                  state_q   <= fast_ack ? ACKED : WAIT_ACK;
                  is_read_q <= cyc_read;
                  wait_q    <= 2'(ACK_DELAY - 2);
               end
            end
            WAIT_ACK: begin
               if (!stb) begin
                  state_q <= IDLE;
               end else if (wait_q == 2'h0) begin
                  state_q <= ACKED;
               end else begin
                  wait_q <= wait_q - 2'h1;
               end
            end
            ACKED: begin
               // ready and bus released once the host drops its strobe or select
               if (!stb || cs_s2) begin
                  state_q <= IDLE;
                  ack_q   <= 1'b0;
                  drive_q <= 1'b0;
               end
            end
            default: state_q <= IDLE;
         endcase
         // ready and read data load at the acknowledge edge; the bus drive turns on there for reads only
         if (ack_edge) begin
            ack_q   <= 1'b1;
            rdata_q <= rd_val;
            drive_q <= ack_read;
         end
      end
   end

   // write lands in the cycle ready goes low, so ready means stored at every offset but the identity bytes
   wire do_write = ack_edge && !ack_read && writable && (!is_chan || chan_ok);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < 256; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (do_write) begin
         // identity bytes are constants, so writes aimed at them land nowhere
         regs_q[eff_idx] <= dat_s2;
      end
   end

   // ready and the read drive both come from flops set on the acknowledge edge
   assign pins.ready_or_ack_pin = !ack_q;
   assign pins.data_dev         = rdata_q;
   assign pins.data_dev_oe      = drive_q && !cs_s2;
   // channel logic reads the global and pulse-select bytes straight from storage
   assign global_ctrl0          = regs_q[GLOBAL_FIRST];
   assign e1_arbitrary_pulse_select = regs_q[E1_ARB_SEL_OFF];
   assign busy                  = state_q != IDLE;
   wire unused = clk_s2; // sampled host clock; device timing comes from sys_clk
endmodule : host_register_port

// >>> logic/host_bus_master.sv
// host end: drives the port pins from a plain read/write command port
`timescale 1ns/100ps
module host_bus_master
   import host_port_pkg::*;
#(
   parameter logic [2:0] CHIP_SEL = 3'h0,
   parameter int         CLK_DIV  = 4
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire host_port_pkg::port_mode_e mode,
   // command port
   input  wire logic [7:0]                cmd_addr,
   input  wire logic [7:0]                cmd_wdata,
   input  wire logic                      cmd_write,
   input  wire logic                      cmd_read,
   output logic [7:0]                     cmd_rdata,
   output logic                           cmd_busy,
   output logic                           cmd_done,
   // pins
   host_port_if.host                      pins
);
   import host_port_pkg::*;

   if (CLK_DIV < 2 || CLK_DIV > 32 || CLK_DIV * SYS_CLK_NS < BUS_CLK_MIN_NS) begin : g_bad_clk_div
      $error("CLK_DIV out of range");
   end

   typedef enum logic [2:0] {H_IDLE, H_SEL, H_LATCH, H_STROBE, H_END} hst_e;

   hst_e       st_q;
   logic [7:0] addr_q, wdata_q, rdata_q;
   logic       wr_q, cs_n_q, lat_q, stb_q, done_q, oe_q;
   logic [3:0] cnt_q, div_q;
   logic       bclk_q, ack_s1, ack_s2;
   logic [7:0] dd_s1, dd_s2;

   always_ff @(posedge sys_clk) begin
      ack_s1 <= pins.ready_or_ack_pin;
      ack_s2 <= ack_s1;
      dd_s1  <= pins.data_dev;
      dd_s2  <= dd_s1;
   end

   // bus clock divided from sys_clk, 50 percent duty
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_q  <= 4'h0;
         bclk_q <= 1'b0;
      end else if (div_q == 4'(CLK_DIV / 2 - 1)) begin
         div_q  <= 4'h0;
         bclk_q <= !bclk_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q    <= H_IDLE;
         addr_q  <= 8'h00;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
         wr_q    <= 1'b0;
         cs_n_q  <= 1'b1;
         lat_q   <= 1'b0;
         stb_q   <= 1'b0;
         done_q  <= 1'b0;
         oe_q    <= 1'b0;
         cnt_q   <= 4'h0;
      end else begin
         done_q <= 1'b0;
         unique case (st_q)
            H_IDLE: begin
               lat_q <= mode != MODE_SYNC ? 1'b0 : 1'b1;
               if (cmd_write || cmd_read) begin
                  addr_q  <= cmd_addr;
                  wdata_q <= cmd_wdata;
                  wr_q    <= cmd_write;
                  cs_n_q  <= 1'b0;
                  lat_q   <= mode != MODE_SYNC; // address latch high, or start driven low in sync mode
                  st_q    <= H_SEL;
               end
            end
            H_SEL: begin
               // falling latch or low start captures the index
               lat_q <= 1'b0;
               oe_q  <= wr_q;
               cnt_q <= 4'(CS_TO_STB_CYC + 2);
               st_q  <= H_LATCH;
            end
            H_LATCH: begin
               if (cnt_q == 4'h0) begin
                  stb_q <= 1'b1;
                  st_q  <= H_STROBE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            H_STROBE: begin
               if (!ack_s2) begin
                  rdata_q <= dd_s2;
                  stb_q   <= 1'b0;
                  st_q    <= H_END;
               end
            end
            H_END: begin
               if (ack_s2) begin
                  cs_n_q <= 1'b1;
                  oe_q   <= 1'b0;
                  lat_q  <= mode == MODE_SYNC;
                  done_q <= 1'b1;
                  st_q   <= H_IDLE;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   wire async_m = mode == MODE_ASYNC;
   assign pins.index              = {CHIP_SEL, addr_q};
   assign pins.cs_n               = cs_n_q;
   assign pins.latch_or_start_pin = lat_q;
   // async: rd pin is read strobe, rw pin store strobe; else rd pin strobe, rw pin direction
   assign pins.rd_stb_n  = async_m ? !(stb_q && !wr_q) : !stb_q;
   assign pins.wr_rw     = async_m ? !(stb_q && wr_q) : !wr_q;
   assign pins.bus_clk   = bclk_q;
   assign pins.data_host    = wdata_q;
   assign pins.data_host_oe = oe_q;
   assign cmd_rdata = rdata_q;
   assign cmd_busy  = st_q != H_IDLE;
   assign cmd_done  = done_q;
endmodule : host_bus_master

// >>> verification/host_port_properties.sv
// concurrent checks on the pins between host master and register port
`timescale 1ns/100ps
module host_port_properties
   import host_port_pkg::*;
#(
   parameter logic [2:0] CHIP_SEL = 3'h0
) (
   // clock, reset and strap
   input wire logic                      sys_clk,
   input wire logic                      rst,
   input wire host_port_pkg::port_mode_e mode,
   // pins
   input wire logic [10:0]               index,
   input wire logic                      cs_n,
   input wire logic                      rd_stb_n,
   input wire logic                      wr_rw,
   input wire logic                      ready_or_ack_pin,
   input wire logic                      data_dev_oe
);
   import host_port_pkg::*;
   wire sel = !cs_n && (index[10:8] == CHIP_SEL);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // 150 ns is three sys_clk cycles
   a_read_ack_time: assert property ($fell(rd_stb_n) && sel && mode == MODE_ASYNC |-> ##[1:3] !ready_or_ack_pin)
      else $error("async read not acknowledged in time");
   a_write_ack_time: assert property ($fell(wr_rw) && sel && mode == MODE_ASYNC |-> ##[1:3] !ready_or_ack_pin)
      else $error("async write not acknowledged in time");
   a_sync_ack_time: assert property ($fell(rd_stb_n) && sel && mode == MODE_SYNC |-> ##[1:3] !ready_or_ack_pin)
      else $error("sync transfer not acknowledged in time");
   a_dstb_ack_time: assert property ($fell(rd_stb_n) && sel && mode == MODE_DSTROBE |-> ##[1:3] !ready_or_ack_pin)
      else $error("data strobe not acknowledged in time");
   a_drive_only_read: assert property (data_dev_oe |-> !cs_n && wr_rw)
      else $error("device drives data outside a read");
   a_ack_release: assert property ($rose(rd_stb_n) || (mode == MODE_ASYNC && $rose(wr_rw)) |-> ##[1:4] ready_or_ack_pin)
      else $error("ready not released after strobe end");
   a_ack_holds: assert property (!ready_or_ack_pin && !rd_stb_n |=> !ready_or_ack_pin)
      else $error("acknowledge dropped while strobe low");
   a_ack_needs_select: assert property ($fell(ready_or_ack_pin) |-> sel)
      else $error("acknowledge without selection");
   a_idle_ready: assert property (cs_n |-> ready_or_ack_pin && !data_dev_oe)
      else $error("unselected port active");
   a_ack_cause: assert property ($fell(ready_or_ack_pin) |-> !$past(rd_stb_n) || (mode == MODE_ASYNC && !$past(wr_rw)))
      else $error("acknowledge without strobe");
endmodule : host_port_properties

// >>> verification/tb.sv
// self-checking bench: host master facing register port, plus a bench-driven second port
`timescale 1ns/100ps
module tb;
   import host_port_pkg::*;
   localparam logic [7:0] ID_VAL  = 8'h3c; // arbitrary value
   localparam logic [7:0] REV_VAL = 8'h07; // arbitrary value
   logic       sys_clk   = 1'b0;
   logic       rst       = 1'b1;
   port_mode_e mode      = MODE_ASYNC;
   logic [7:0] cmd_addr  = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic       cmd_write = 1'b0;
   logic       cmd_read  = 1'b0;
   logic [7:0] cmd_rdata, global_ctrl0, e1_sel, e1_sel_b;
   logic       cmd_done, cmd_busy, port_busy;
   int         miscompares     = 0;
   int         samples_checked = 0;
   logic [7:0] addrs [10] = '{8'h00, 8'h0f, 8'h10, 8'hdf, 8'he0, 8'heb, 8'hec, 8'hf4, 8'hfd, 8'h5a};
   host_port_if u_host_port_if ();
   host_port_if u_host_port_if_b ();
   always #25 sys_clk = ~sys_clk;
   always #200 u_host_port_if_b.bus_clk = ~u_host_port_if_b.bus_clk;
   host_bus_master u_host_bus_master (.sys_clk(sys_clk), .rst(rst), .mode(mode), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata),
      .cmd_busy(cmd_busy), .cmd_done(cmd_done), .pins(u_host_port_if.host));
   host_register_port #(.DEV_ID(ID_VAL), .DEV_REV(REV_VAL)) u_host_register_port (.sys_clk(sys_clk),
      .rst(rst), .mode(mode), .pins(u_host_port_if.device), .global_ctrl0(global_ctrl0),
      .e1_arbitrary_pulse_select(e1_sel), .busy(port_busy));
   // second port: bench drives its pins with the latch tied high
   host_register_port u_host_register_port_b (.sys_clk(sys_clk), .rst(rst), .mode(MODE_ASYNC),
      .pins(u_host_port_if_b.device), .global_ctrl0(), .e1_arbitrary_pulse_select(e1_sel_b), .busy());
   host_port_properties #(.CHIP_SEL(3'h0)) u_host_port_properties (.sys_clk(sys_clk), .rst(rst), .mode(mode),
      .index(u_host_port_if.index), .cs_n(u_host_port_if.cs_n), .rd_stb_n(u_host_port_if.rd_stb_n),
      .wr_rw(u_host_port_if.wr_rw), .ready_or_ack_pin(u_host_port_if.ready_or_ack_pin),
      .data_dev_oe(u_host_port_if.data_dev_oe));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   function automatic logic [7:0] patt(input logic [7:0] a);
      return a ^ {6'h25, mode};
   endfunction : patt

   task automatic apply_reset();
      rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : apply_reset

   task automatic do_cmd(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
      cmd_addr  <= addr;
      cmd_wdata <= wdata;
      cmd_write <= wr;
      cmd_read  <= !wr;
      @(posedge sys_clk);
      cmd_write <= 1'b0;
      cmd_read  <= 1'b0;
      repeat (200) begin
         @(negedge sys_clk);
         if (cmd_done === 1'b1) break;
      end
      check({7'h00, cmd_done}, 8'h01);
      check({7'h00, cmd_busy}, 8'h00);
      check({7'h00, port_busy}, 8'h00);
      @(posedge sys_clk);
   endtask : do_cmd

   task automatic sc_id_regs();
      do_cmd(1'b0, 8'hec, 8'h00);
      check(cmd_rdata, REG_RESET);
      do_cmd(1'b1, 8'hfe, 8'hff);
      do_cmd(1'b1, 8'hff, 8'h00);
      do_cmd(1'b0, 8'hfe, 8'h00);
      check(cmd_rdata, ID_VAL);
      do_cmd(1'b0, 8'hff, 8'h00);
      check(cmd_rdata, REV_VAL);
   endtask : sc_id_regs

   task automatic sc_reg_map();
      // all writes first so aliasing between neighbouring blocks shows on readback
      foreach (addrs[i]) do_cmd(1'b1, addrs[i], patt(addrs[i]));
      foreach (addrs[i]) begin
         do_cmd(1'b0, addrs[i], 8'h00);
         check(cmd_rdata, patt(addrs[i]));
      end
      check(global_ctrl0, patt(8'he0));
      check(e1_sel, patt(8'hf4));
   endtask : sc_reg_map

   task automatic pin_write(input logic [10:0] idx, input logic [7:0] data, input logic exp_ack);
      logic seen;
      seen = 1'b0;
      u_host_port_if_b.index        <= idx;
      u_host_port_if_b.cs_n         <= 1'b0;
      u_host_port_if_b.data_host    <= data;
      u_host_port_if_b.data_host_oe <= 1'b1;
      repeat (2) @(posedge sys_clk);
      u_host_port_if_b.wr_rw <= 1'b0;
      repeat (6) begin
         @(posedge sys_clk);
         seen = seen | (u_host_port_if_b.ready_or_ack_pin === 1'b0);
      end
      check({7'h00, seen}, {7'h00, exp_ack});
      u_host_port_if_b.wr_rw        <= 1'b1;
      u_host_port_if_b.data_host    <= ~data;
      u_host_port_if_b.data_host_oe <= 1'b0;
      repeat (6) @(posedge sys_clk);
      u_host_port_if_b.cs_n <= 1'b1;
      @(posedge sys_clk);
   endtask : pin_write

   task automatic sc_tied_latch();
      pin_write(11'h0f4, 8'h5c, 1'b1);
      check(e1_sel_b, 8'h5c);
      pin_write(11'h5f4, 8'ha3, 1'b0);
      check(e1_sel_b, 8'h5c);
   endtask : sc_tied_latch

   initial begin
      u_host_port_if_b.index              = 11'h000;
      u_host_port_if_b.cs_n               = 1'b1;
      u_host_port_if_b.latch_or_start_pin = 1'b1;
      u_host_port_if_b.rd_stb_n           = 1'b1;
      u_host_port_if_b.wr_rw              = 1'b1;
      u_host_port_if_b.bus_clk            = 1'b0;
      u_host_port_if_b.data_host          = 8'h00;
      u_host_port_if_b.data_host_oe       = 1'b0;
      for (int m = 0; m < 3; m++) begin
         mode <= port_mode_e'(m);
         apply_reset();
         sc_id_regs();
         sc_reg_map();
      end
      sc_tied_latch();
      complete_run();
   end

   // whole run needs well under a millisecond
   initial begin
      #2000000;
      miscompares++;
      $display("[ERR] %0t ns: watchdog expired", $time);
      complete_run();
   end
endmodule : tb
